// File: ddf_addr_gen.sv
// ddf_addr_gen: forms the memory address of one descriptor element.
// assumes the base pointer is aligned to the descriptor region size.
`timescale 1ns/100ps
`default_nettype none
module ddf_addr_gen (
	input  wire logic [31:0] base,  // primary region base pointer
	input  wire logic        alt,   // alternate structure select
	input  wire logic [3:0]  chan,  // channel number
	input  wire logic [3:0]  elem,  // element byte offset
	output logic      [31:0] addr   // element address
);
	import ddf_pkg::*;
	// low bits of base are ignored; alignment is the host's duty
	assign addr = {base[31:SEL_BIT+1], alt, chan, elem};
endmodule
`default_nettype wire

// File: ddf_cfg_dec.sv
// ddf_cfg_dec: decodes a packed channel control word.
// assumes the word was fetched from the descriptor region unchanged.
`timescale 1ns/100ps
`default_nettype none
module ddf_cfg_dec (
	input  wire ddf_pkg::ddf_cfg_t cfg,  // control word
	output ddf_pkg::ddf_dec_t      dec   // decoded fields
);
	import ddf_pkg::*;
	logic [10:0] span;

	// a step narrower than the data width is reserved
	function automatic logic inc_bad(input logic [1:0] inc,
					 input logic [1:0] size);
		return (inc != INC_NONE) && (inc < size);
	endfunction

	// codes above nine saturate: a cycle never re-arbitrates
	assign span = (cfg.r_power >= RPOW_MAX) ? CNT_MAX
		: (CNT_ONE << cfg.r_power);
	assign dec.total = {1'b0, cfg.n_minus_1} + CNT_ONE;
	assign dec.batch = (span < dec.total) ? span : dec.total;
	assign dec.size = cfg.src_size;
	assign dec.size_bad = (cfg.src_size == SIZE_RSV);
	assign dec.inc_bad = inc_bad(cfg.dst_inc, cfg.src_size)
		| inc_bad(cfg.src_inc, cfg.src_size);
	assign dec.invalid = (cfg.mode == MODE_STOP);
endmodule
`default_nettype wire

// File: ddf_fetch.sv
// ddf_fetch: descriptor fetch, decode and control write-back engine.
// assumes a Wishbone classic host and one AHB-Lite memory slave;
// the data mover pulses xfer_done once per finished transfer.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ddf_fetch (
	input  wire logic        core_clk,  // system clock
	input  wire logic        rst,       // sync reset, active high
	input  wire logic        wb_cyc_i,  // wishbone cycle
	input  wire logic        wb_stb_i,  // wishbone strobe
	input  wire logic        wb_we_i,   // wishbone write
	input  wire logic [7:0]  wb_adr_i,  // wishbone byte address
	input  wire logic [3:0]  wb_sel_i,  // wishbone byte lanes
	input  wire logic [31:0] wb_dat_i,  // wishbone write data
	output logic      [31:0] wb_dat_o,  // wishbone read data
	output logic             wb_ack_o,  // wishbone acknowledge
	output logic      [31:0] haddr,     // AHB address
	output logic      [1:0]  htrans,    // AHB transfer type
	output logic             hwrite,    // AHB write
	output logic      [2:0]  hsize,     // AHB size
	output logic      [3:0]  hprot,     // AHB protection
	output logic      [31:0] hwdata,    // AHB write data
	input  wire logic [31:0] hrdata,    // AHB read data
	input  wire logic        hready,    // AHB ready
	input  wire logic        hresp,     // AHB error response
	input  wire logic        xfer_done, // one data transfer finished
	output ddf_pkg::ddf_run_t run_o     // decoded batch for the mover
);
	import ddf_pkg::*;

	////////////////////////////////////////////////////////////////
	ddf_state_t  state_q;
	ddf_cfg_t    cfg_q;
	ddf_dec_t    dec;
	logic [31:0] base_q;
	logic [31:0] src_end_q;
	logic [31:0] dst_end_q;
	logic [31:0] elem_addr;
	logic [31:0] rd_word;
	logic [31:0] haddr_q;
	logic [31:0] hwdata_q;
	logic [31:0] wb_dat_q;
	logic [3:0]  chan_q;
	logic [3:0]  elem_q;
	logic [1:0]  htrans_q;
	logic        alt_q;
	logic        hwrite_q;
	logic        ack_q;
	logic [10:0] left_q;
	logic [10:0] remain;
	ddf_cfg_t    wb_cfg;
	ddf_run_t    run_q;
	logic        done_q;
	logic        err_q;
	logic        inval_q;
	logic        size_q;
	logic        inc_q;
	logic        end_q;
	logic        bus_req;
	logic        wr_req;
	logic        start_req;
	logic        clr_req;
	logic        set_done;
	logic        set_err;
	logic        set_inval;
	logic        fetch_last;
	logic        xfer_last;

	function automatic logic reg_is(input logic [7:0] a,
					input logic [7:0] r);
		return a[7:2] == r[7:2];
	endfunction

	ddf_addr_gen u_addr (
		.base (base_q),
		.alt  (alt_q),
		.chan (chan_q),
		.elem (elem_q),
		.addr (elem_addr)
	);

	ddf_cfg_dec u_dec (
		.cfg (cfg_q),
		.dec (dec)
	);

	////////////////////////////////////////////////////////////////
	// host bus strobes
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_req = bus_req & wb_we_i;
	assign start_req = wr_req & reg_is(wb_adr_i, REG_CMD)
		& wb_sel_i[0] & wb_dat_i[CMD_START];
	assign clr_req = wr_req & reg_is(wb_adr_i, REG_STATUS) & wb_sel_i[0];

	assign fetch_last = (state_q == ST_FETCH_D) & hready
		& ~hresp & (elem_q == OFS_CFG);
	assign xfer_last = (state_q == ST_RUN) & xfer_done
		& (left_q == CNT_ONE);
	assign set_err = ((state_q == ST_FETCH_D) | (state_q == ST_WB_D))
		& hready & hresp;
	assign set_inval = (state_q == ST_DECODE)
		& (dec.invalid | dec.size_bad);
	assign set_done = (state_q == ST_WB_D) & hready & ~hresp;

	// updated control word written back after the batch
	assign remain = dec.total - dec.batch;
	always_comb begin
		wb_cfg = cfg_q;
		wb_cfg.dst_size = cfg_q.src_size;
		wb_cfg.n_minus_1 = (remain == '0) ? '0
			: remain[9:0] - 10'h001;
		if (remain == '0) begin
			wb_cfg.mode = MODE_STOP;
		end
	end

	////////////////////////////////////////////////////////////////
	// sequencer and AHB-Lite master; single word transfers only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q  <= ST_IDLE;
			haddr_q  <= RST_WORD;
			htrans_q <= HTR_IDLE;
			hwrite_q <= 1'b0;
			hwdata_q <= RST_WORD;
			elem_q   <= OFS_SRC;
			left_q   <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_req) begin
						elem_q  <= OFS_SRC;
						state_q <= ST_LAUNCH;
					end
				end
				ST_LAUNCH: begin
					haddr_q  <= elem_addr;
					htrans_q <= HTR_NONSEQ;
					hwrite_q <= 1'b0;
					state_q  <= ST_FETCH_A;
				end
				ST_FETCH_A: begin
					if (hready) begin
						htrans_q <= HTR_IDLE;
						state_q  <= ST_FETCH_D;
					end
				end
				ST_FETCH_D: begin
					if (hready && hresp) begin
						state_q <= ST_IDLE;
					end else if (fetch_last) begin
						state_q <= ST_DECODE;
					end else if (hready) begin
						// never reaches the fourth word
						elem_q  <= (elem_q == OFS_SRC) ? OFS_DST
							: OFS_CFG;
						state_q <= ST_LAUNCH;
					end
				end
				ST_DECODE: begin
					if (dec.invalid || dec.size_bad) begin
						state_q <= ST_IDLE;
					end else begin
						left_q  <= dec.batch;
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (xfer_last) begin
						// only the control word is ever written
						haddr_q  <= elem_addr;
						htrans_q <= HTR_NONSEQ;
						hwrite_q <= 1'b1;
						hwdata_q <= wb_cfg;
						state_q  <= ST_WB_A;
					end else if (xfer_done) begin
						left_q <= left_q - CNT_ONE;
					end
				end
				ST_WB_A: begin
					if (hready) begin
						htrans_q <= HTR_IDLE;
						state_q  <= ST_WB_D;
					end
				end
				ST_WB_D: begin
					if (hready) begin
						hwrite_q <= 1'b0;
						state_q  <= ST_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// descriptor words and the channel being served
	assign rd_word = hrdata;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			src_end_q <= RST_WORD;
			dst_end_q <= RST_WORD;
			cfg_q     <= RST_WORD;
			chan_q    <= '0;
			alt_q     <= 1'b0;
		end else begin
			if (start_req && state_q == ST_IDLE) begin
				chan_q <= wb_dat_i[CMD_CH_LSB +: 4];
				alt_q  <= wb_dat_i[CMD_ALT];
			end
			if (state_q == ST_FETCH_D && hready && !hresp) begin
				unique case (elem_q)
					OFS_SRC: src_end_q <= rd_word;
					OFS_DST: dst_end_q <= rd_word;
					default: cfg_q <= rd_word;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// registers and status; done, err, invalid and end are sticky, a set in the clear cycle wins; size and inc reload at each decode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			base_q  <= RST_WORD;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
			inval_q <= 1'b0;
			size_q  <= 1'b0;
			inc_q   <= 1'b0;
			end_q   <= 1'b0;
		end else begin
			if (wr_req && reg_is(wb_adr_i, REG_BASE)) begin
				for (int i = 0; i < 4; i++) begin
					if (wb_sel_i[i]) begin
						base_q[8*i +: 8] <= wb_dat_i[8*i +: 8];
					end
				end
			end
			done_q  <= set_done
				| (done_q & ~(clr_req & wb_dat_i[STS_DONE]));
			err_q   <= set_err
				| (err_q & ~(clr_req & wb_dat_i[STS_ERR]));
			inval_q <= set_inval
				| (inval_q & ~(clr_req & wb_dat_i[STS_INVALID]));
			end_q   <= (set_done & (remain == '0))
				| (end_q & ~(clr_req & wb_dat_i[STS_END]));
			if (state_q == ST_DECODE) begin
				size_q <= dec.size_bad;
				inc_q  <= dec.inc_bad;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux; one wait state, unmapped reads return zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_q    <= 1'b0;
			wb_dat_q <= RST_WORD;
		end else begin
			ack_q    <= bus_req;
			wb_dat_q <= RST_WORD;
			if (bus_req && !wb_we_i) begin
				unique case ({wb_adr_i[7:2], 2'b00})
					REG_BASE: wb_dat_q <= base_q;
					REG_ALT: wb_dat_q <= {base_q[31:SEL_BIT+1],
						9'h000} | ALT_OFS;
					REG_STATUS: begin
						wb_dat_q[STS_BUSY]    <= state_q != ST_IDLE;
						wb_dat_q[STS_DONE]    <= done_q;
						wb_dat_q[STS_ERR]     <= err_q;
						wb_dat_q[STS_INVALID] <= inval_q;
						wb_dat_q[STS_SIZE]    <= size_q;
						wb_dat_q[STS_INC]     <= inc_q;
						wb_dat_q[STS_END]     <= end_q;
					end
					REG_SRC: wb_dat_q <= src_end_q;
					REG_DST: wb_dat_q <= dst_end_q;
					REG_CFG: wb_dat_q <= cfg_q;
					REG_LEFT: wb_dat_q <= {21'h00_0000, left_q};
					default: wb_dat_q <= RST_WORD;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// batch parameters handed to the data mover
	always_ff @(posedge core_clk) begin
		if (rst) begin
			run_q <= '0;
		end else begin
			run_q.active <= (state_q == ST_DECODE) ? !set_inval
				: (state_q == ST_RUN) && !xfer_last;
			run_q.size     <= dec.size;
			run_q.src_inc  <= cfg_q.src_inc;
			run_q.dst_inc  <= cfg_q.dst_inc;
			run_q.rd_hprot <= cfg_q.src_prot;
			run_q.wr_hprot <= cfg_q.dst_prot;
			run_q.left     <= (state_q == ST_DECODE) ? dec.batch
				: left_q - (xfer_done ? CNT_ONE : '0);
			run_q.src_end  <= src_end_q;
			run_q.dst_end  <= dst_end_q;
		end
	end

	assign wb_dat_o = wb_dat_q;
	assign wb_ack_o = ack_q;
	assign haddr    = haddr_q;
	assign htrans   = htrans_q;
	assign hwrite   = hwrite_q;
	assign hsize    = HSZ_WORD;
	assign hprot    = HPROT_DESC;
	assign hwdata   = hwdata_q;
	assign run_o    = run_q;

	////////////////////////////////////////////////////////////////
	sequence s_cfg_taken;
		fetch_last;
	endsequence
	sequence s_decide;
		(state_q == ST_DECODE) ##1
			(state_q == ST_RUN || state_q == ST_IDLE);
	endsequence

	a_cfg_fetch_seq: assert property (@(posedge core_clk) disable iff (rst)
		s_cfg_taken |=> s_decide)
		else $error("decode did not follow control fetch");
	a_addr_fields: assert property (@(posedge core_clk) disable iff (rst)
		htrans == HTR_NONSEQ |-> haddr[SEL_BIT] == alt_q
			&& haddr[7:4] == chan_q)
		else $error("descriptor address fields wrong");
	a_elem_used: assert property (@(posedge core_clk) disable iff (rst)
		htrans == HTR_NONSEQ |-> haddr[3:0] == OFS_SRC
			|| haddr[3:0] == OFS_DST || haddr[3:0] == OFS_CFG)
		else $error("fourth descriptor word accessed");
	a_no_ptr_write: assert property (@(posedge core_clk) disable iff (rst)
		htrans == HTR_NONSEQ && hwrite |-> haddr[3:0] == OFS_CFG)
		else $error("end pointer written");
	a_fetch_before: assert property (@(posedge core_clk) disable iff (rst)
		$rose(run_q.active) |-> $past(state_q, 2) == ST_FETCH_D)
		else $error("batch began without full fetch");
	a_alt_base: assert property (@(posedge core_clk) disable iff (rst)
		bus_req && !wb_we_i && reg_is(wb_adr_i, REG_ALT) |=>
			wb_ack_o && wb_dat_o[SEL_BIT] && wb_dat_o[7:0] == 8'h00)
		else $error("alternate base read wrong");
	a_stop_last: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_WB_A && remain == '0 |->
			hwdata[2:0] == MODE_STOP && hwdata[13:4] == 10'h000)
		else $error("final write-back not stopped");
	a_count_wb: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_WB_A && remain != '0 |->
			{1'b0, hwdata[13:4]} + CNT_ONE == remain)
		else $error("remaining count written back wrong");
	a_size_copy: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_WB_A |-> hwdata[29:28] == cfg_q.src_size)
		else $error("destination size not copied");
	a_batch_len: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_DECODE && !set_inval |=> left_q == dec.batch
			&& left_q <= CNT_MAX && left_q != '0)
		else $error("batch length wrong");
	a_hprot_route: assert property (@(posedge core_clk) disable iff (rst)
		run_q.active |-> run_q.wr_hprot == cfg_q.dst_prot
			&& run_q.rd_hprot == cfg_q.src_prot)
		else $error("protection bits misrouted");
	a_invalid_stop: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_DECODE && dec.invalid |=> state_q == ST_IDLE
			&& inval_q && !run_q.active)
		else $error("invalid descriptor not stopped");
endmodule
`default_nettype wire

// File: ddf_fetch_end.sv
// ddf_fetch_end: deliberately empty; the engine lives in ddf_fetch.
// assumes nothing of its surroundings and defines no module.

// File: ddf_mem_model.sv
// ddf_mem_model: AHB-Lite system memory holding the descriptor region.
// assumes the bench preloads words through the mem array.
`timescale 1ns/100ps
`default_nettype none
module ddf_mem_model (
	input  wire logic        core_clk, // system clock
	input  wire logic        rst,      // sync reset, active high
	input  wire logic [31:0] haddr,    // AHB address
	input  wire logic [1:0]  htrans,   // AHB transfer type
	input  wire logic        hwrite,   // AHB write
	input  wire logic [31:0] hwdata,   // AHB write data
	input  wire logic        slow,     // one wait state per transfer
	output logic      [31:0] hrdata,   // AHB read data
	output logic             hready,   // AHB ready
	output logic             hresp     // AHB error response
);
	// one contiguous region, indexed by the low address bits only
	logic [31:0] mem [0:127];
	logic [31:0] rd_log [$];
	logic [31:0] last_q;
	logic [6:0]  a_q;
	logic [6:0]  wa_q;
	logic        ph_q;
	logic        wr_q;
	logic        wait_q;
	int          wr_cnt = 0;
	int          ptr_wr = 0;

	assign hready = ~wait_q;
	assign hresp  = 1'b0;
	// outside a read data phase the bus shows the inverse of the last word
	assign hrdata = (ph_q & ~wr_q & hready) ? mem[a_q] : ~last_q;

	always @(posedge core_clk) begin
		if (rst) begin
			ph_q   <= 1'b0;
			wait_q <= 1'b0;
			last_q <= 32'h0000_0000;
		end else if (hready) begin
			ph_q   <= htrans[1];
			wr_q   <= hwrite;
			a_q    <= haddr[8:2];
			wait_q <= htrans[1] & slow;
			last_q <= hrdata;
			if (htrans[1] & ~hwrite)
				rd_log.push_back(haddr);
			if (ph_q & wr_q) begin
				mem[a_q] <= hwdata;
				wa_q     <= a_q;
				wr_cnt   <= wr_cnt + 1;
				if (a_q[1:0] != 2'h2)
					ptr_wr <= ptr_wr + 1;
			end
		end else
			wait_q <= 1'b0;
	end
endmodule
`default_nettype wire

// File: ddf_pkg.sv
// ddf_pkg: constants, register map and carrier types of the descriptor
// fetch and decode block; assumes AHB-Lite memory and a Wishbone host.
// Behaviour
// - address bit 8 alternate, 7:4 channel, 3:0 element
// - elements 0, 4, 8 used; fourth word untouched
// - alternate base readable from a register
// - pointers read every batch, never written
// - destination step decode, narrower steps flagged reserved
// - source step decode, code 11 holds address
// - source size byte, half, word; 11 reserved
// - bits 23:21 give write protection bits
// - bits 20:18 give read protection bits
// - batch is two to power, capped 1024
// - count field holds transfers minus one
// - remaining count written back at batch end
// - mode field decoded, stop means invalid
// - mode rewritten to stop after last transfer
// - source size used; copied into destination size
// - control fetched per batch, written back after
package ddf_pkg;
	// register byte offsets on the host bus
	localparam logic [7:0]  REG_BASE    = 8'h00;
	localparam logic [7:0]  REG_ALT     = 8'h04;
	localparam logic [7:0]  REG_CMD     = 8'h08;
	localparam logic [7:0]  REG_STATUS  = 8'h0c;
	localparam logic [7:0]  REG_SRC     = 8'h10;
	localparam logic [7:0]  REG_DST     = 8'h14;
	localparam logic [7:0]  REG_CFG     = 8'h18;
	localparam logic [7:0]  REG_LEFT    = 8'h1c;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam int          CMD_START   = 0;
	localparam int          CMD_CH_LSB  = 1;
	localparam int          CMD_ALT     = 5;
	localparam int          STS_BUSY    = 0;
	localparam int          STS_DONE    = 1;
	localparam int          STS_ERR     = 2;
	localparam int          STS_INVALID = 3;
	localparam int          STS_SIZE    = 4;
	localparam int          STS_INC     = 5;
	localparam int          STS_END     = 6;
	// descriptor layout in memory
	localparam int          SEL_BIT     = 8;
	localparam logic [3:0]  OFS_SRC     = 4'h0;
	localparam logic [3:0]  OFS_DST     = 4'h4;
	localparam logic [3:0]  OFS_CFG     = 4'h8;
	localparam logic [31:0] ALT_OFS     = 32'h0000_0100;
	// control word encodings
	localparam logic [1:0]  INC_NONE    = 2'h3;
	localparam logic [1:0]  SIZE_RSV    = 2'h3;
	localparam logic [3:0]  RPOW_MAX    = 4'ha;
	localparam logic [2:0]  MODE_STOP   = 3'h0;
	localparam logic [10:0] CNT_ONE     = 11'h001;
	localparam logic [10:0] CNT_MAX     = 11'h400;
	// AHB-Lite master encodings
	localparam logic [1:0]  HTR_IDLE    = 2'h0;
	localparam logic [1:0]  HTR_NONSEQ  = 2'h2;
	localparam logic [2:0]  HSZ_WORD    = 3'h2;
	localparam logic [3:0]  HPROT_DESC  = 4'h3;

	typedef struct packed {
		logic [1:0] dst_inc;
		logic [1:0] dst_size;
		logic [1:0] src_inc;
		logic [1:0] src_size;
		logic [2:0] dst_prot;
		logic [2:0] src_prot;
		logic [3:0] r_power;
		logic [9:0] n_minus_1;
		logic       next_useburst;
		logic [2:0] mode;
	} ddf_cfg_t;

	typedef struct packed {
		logic [10:0] total;
		logic [10:0] batch;
		logic [1:0]  size;
		logic        size_bad;
		logic        inc_bad;
		logic        invalid;
	} ddf_dec_t;

	typedef struct packed {
		logic        active;
		logic [1:0]  size;
		logic [1:0]  src_inc;
		logic [1:0]  dst_inc;
		logic [2:0]  rd_hprot;
		logic [2:0]  wr_hprot;
		logic [10:0] left;
		logic [31:0] src_end;
		logic [31:0] dst_end;
	} ddf_run_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_LAUNCH, ST_FETCH_A, ST_FETCH_D,
		ST_DECODE, ST_RUN, ST_WB_A, ST_WB_D
	} ddf_state_t;
endpackage

// File: testbench.sv
// testbench: drives ddf_fetch over Wishbone and checks descriptor traffic.
// assumes ddf_mem_model answers the AHB-Lite master side.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ddf_pkg::*;
	localparam logic [31:0] BASE = 32'h0000_0200;
	logic              core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        [7:0] wb_adr_i;
	logic        [3:0] wb_sel_i, hprot;
	logic       [31:0] wb_dat_i, wb_dat_o, haddr, hwdata, hrdata, q;
	logic        [1:0] htrans;
	logic        [2:0] hsize;
	logic              hwrite, hready, hresp, xfer_done, slow;
	ddf_run_t          run_o, seen;
	int                err_total = 0, cmp_count = 0, cyc_n = 0;

	ddf_fetch uut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata),
		.hrdata(hrdata), .hready(hready), .hresp(hresp),
		.xfer_done(xfer_done), .run_o(run_o));
	ddf_mem_model mem_i (.core_clk(core_clk), .rst(rst), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .slow(slow),
		.hrdata(hrdata), .hready(hready), .hresp(hresp));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_total++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// classic single cycle; the slave decides when ack comes
	task automatic wb_io(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		if (n == 20)
			ck(n, 0);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb_io(1'b0, a, 32'h0000_0000);
		ck(q, e);
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			wb_io(1'b0, REG_STATUS, 32'h0000_0000);
			n++;
		end while (q[STS_BUSY] !== 1'b0 && n < 40);
		ck(q[STS_BUSY], 32'h0000_0000);
	endtask

	function automatic logic [31:0] cw(input logic [1:0] di, ds, si, ss,
		input logic [5:0] pr, input logic [3:0] r, input logic [9:0] n1,
		input logic [2:0] md);
		return {di, ds, si, ss, pr, r, n1, 1'b0, md};
	endfunction

	task automatic load(input logic a, input logic [3:0] c,
		input logic [31:0] cfg);
		mem_i.mem[{a, c, 2'h0}] = 32'hab00_0000 | {a, c};
		mem_i.mem[{a, c, 2'h1}] = 32'hcd00_0000 | {a, c};
		mem_i.mem[{a, c, 2'h2}] = cfg;
		mem_i.mem[{a, c, 2'h3}] = 32'h0c0c_0c0c;
	endtask

	// start one batch, check the fetch, give k transfers, await write-back
	task automatic run_batch(input logic a, input logic [3:0] c,
		input int k);
		int n;
		int w;
		n = mem_i.wr_cnt;
		mem_i.rd_log.delete();
		wb_io(1'b1, REG_CMD, {26'h0, a, c, 1'b1});
		w = 0;
		while (run_o.active !== 1'b1 && w < 100) begin
			@(posedge core_clk);
			w++;
		end
		seen = run_o;
		ck(mem_i.rd_log.size(), 3);
		for (int i = 0; i < 3; i++)
			ck(mem_i.rd_log[i], BASE + {a, c, 4'h0} + 32'(i * 4));
		ck(mem_i.wr_cnt, n);
		ck(hsize, HSZ_WORD);
		ck(hprot, HPROT_DESC);
		xfer_done <= 1'b1;
		repeat (k) @(posedge core_clk);
		xfer_done <= 1'b0;
		w = 0;
		while (mem_i.wr_cnt == n && w < 100) begin
			@(posedge core_clk);
			w++;
		end
		ck(mem_i.wr_cnt, n + 1);
		ck(mem_i.wa_q, {a, c, 2'h2});
		wait_idle();
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(REG_ALT, 32'h0000_0100);
		wb_io(1'b1, REG_BASE, BASE);
		wb_io(1'b1, REG_ALT, 32'hffff_ffff);
		rd(REG_ALT, BASE | 32'h0000_0100);
		rd(8'h20, 32'h0000_0000);
		$display("test regs done");
	endtask

	task automatic t_basic;
		load(1'b0, 4'h3, cw(2, 2, 2, 2, 6'h2b, 4'h2, 10'd5, 3'h1));
		run_batch(1'b0, 4'h3, 4);
		ck(seen.size, 2);
		ck({seen.src_inc, seen.dst_inc}, 4'ha);
		ck(seen.rd_hprot, 3'h3);
		ck(seen.wr_hprot, 3'h5);
		ck(seen.left, 4);
		ck(mem_i.mem[7'h0e], cw(2, 2, 2, 2, 6'h2b, 4'h2, 10'd1, 3'h1));
		ck(mem_i.mem[7'h0f], 32'h0c0c_0c0c);
		mem_i.mem[7'h0c] = 32'h1234_5678;
		slow <= 1'b1;
		run_batch(1'b0, 4'h3, 2);
		slow <= 1'b0;
		ck(seen.src_end, 32'h1234_5678);
		ck(seen.dst_end, 32'hcd00_0003);
		ck(seen.left, 2);
		ck(mem_i.mem[7'h0e], cw(2, 2, 2, 2, 6'h2b, 4'h2, 10'd0, 3'h0));
		ck(mem_i.ptr_wr, 0);
		rd(REG_STATUS, 32'h0000_0042);
		wb_io(1'b1, REG_STATUS, 32'h0000_004e);
		rd(REG_STATUS, 32'h0000_0000);
		$display("test basic done");
	endtask

	task automatic t_alt;
		load(1'b1, 4'hf, cw(0, 0, 3, 1, 6'h07, 4'hf, 10'd2, 3'h3));
		run_batch(1'b1, 4'hf, 3);
		ck(seen.left, 3);
		ck(seen.size, 1);
		ck({seen.src_inc, seen.dst_inc}, 4'hc);
		ck({seen.rd_hprot, seen.wr_hprot}, 6'h38);
		ck(seen.src_end, 32'hab00_001f);
		rd(REG_STATUS, 32'h0000_0062);
		ck(mem_i.mem[7'h7e], cw(0, 1, 3, 1, 6'h07, 4'hf, 10'd0, 3'h0));
		wb_io(1'b1, REG_STATUS, 32'h0000_004e);
		$display("test alternate done");
	endtask

	task automatic t_refuse;
		int n;
		logic [31:0] cfgs [2];
		logic [31:0] sts [2];
		cfgs = '{cw(2, 2, 2, 2, 0, 4'h1, 10'd3, 3'h0),
			cw(2, 3, 2, 3, 0, 4'h1, 10'd3, 3'h6)};
		// a reserved size also makes every narrower step reserved
		sts = '{32'h0000_0008, 32'h0000_0038};
		for (int i = 0; i < 2; i++) begin
			n = mem_i.wr_cnt;
			load(1'b0, 4'h5, cfgs[i]);
			wb_io(1'b1, REG_CMD, 32'h0000_000b);
			wait_idle();
			rd(REG_STATUS, sts[i]);
			ck(mem_i.wr_cnt, n);
			wb_io(1'b1, REG_STATUS, 32'h0000_004e);
		end
		$display("test refuse done");
	endtask

	initial begin
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0000_0000;
		xfer_done = 1'b0;
		slow = 1'b0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		rd(REG_BASE, 32'h0000_0000);
		t_regs();
		t_basic();
		t_alt();
		t_refuse();
		final_report();
	end
endmodule
`default_nettype wire
